// ---- design/mcp_pkg.sv ----
package mcp_pkg;

    localparam int DW               = 24;
    localparam int CW               = 16;
    localparam int PDM_BITS         = 64;
    localparam int MCLK_HZ          = 125_000_000;
    localparam int FS_HZ            = 48_000;
    localparam int PDM_HALF_DIV     = MCLK_HZ / (FS_HZ * PDM_BITS * 2);
    localparam int DEC_SHIFT        = DW - 8;
    localparam int HPF_BASE_SHIFT   = 12;
    localparam int HPF_FAST_DROP    = 5;
    localparam int GAIN_SHIFT       = 7;
    localparam int COEF_FRAC        = 15;
    localparam int FIFO_DEPTH       = 4;
    localparam logic [15:0] INIT_LEN_RESET = 16'h0423;

    typedef struct packed {
        logic signed [DW-1:0] a;
        logic signed [DW-1:0] b;
    } mcp_pair_t;

    typedef struct packed {
        logic signed [CW-1:0] a;
        logic signed [CW-1:0] b;
    } mcp_coef_t;

    typedef enum logic [0:0] {
        MCP_IDLE = 1'b0,
        MCP_INIT = 1'b1
    } mcp_init_t;

    // clamp a wide result to the audio word
    function automatic logic signed [DW-1:0] mcp_sat(input logic signed [47:0] v);
        logic signed [47:0] hi;
        logic signed [47:0] lo;
        hi = 48'sd8388607;
        lo = -48'sd8388608;
        if (v > hi)
            return 24'h7fffff;
        else if (v < lo)
            return 24'h800000;
        else
            return v[DW-1:0];
    endfunction

endpackage

// ---- design/mcp_fifo.sv ----
`timescale 1ns/1ps
module mcp_fifo #(
    parameter int W     = 48,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    logic         full;
    logic         empty;

    assign empty     = wr_q == rd_q;
    assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge mclk)
    begin
        if (in_valid && !full)
            mem_q[wr_q[AW-1:0]] <= in_data;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wr_q <= wr_q + 1'b1;
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule // mcp_fifo

// ---- design/mcp_hpf_section.sv ----
`timescale 1ns/1ps
module mcp_hpf_section (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // control
    input  wire logic                  enable,
    input  wire mcp_pkg::mcp_coef_t    coef,
    // samples
    input  wire logic                  in_valid,
    input  wire logic signed [23:0]    in_data,
    output logic                       out_valid,
    output logic signed [23:0]         out_data
);
    import mcp_pkg::*;

    logic signed [DW-1:0] x1_q;
    logic signed [DW-1:0] y1_q;
    logic signed [DW:0]   diff;
    logic signed [47:0]   acc;
    logic signed [DW-1:0] y;

    // y = A(x - x1) - B*y1, Q15 coefficients
    always_comb
    begin
        diff = {in_data[DW-1], in_data} - {x1_q[DW-1], x1_q};
        acc  = (48'(coef.a) * 48'(diff) - 48'(coef.b) * 48'(y1_q)) >>> COEF_FRAC;
        y    = mcp_sat(acc);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            x1_q      <= '0;
            y1_q      <= '0;
            out_valid <= 1'b0;
            out_data  <= '0;
        end
        else
        begin
            out_valid <= in_valid;
            if (!enable)
            begin
                x1_q <= '0;
                y1_q <= '0;
                if (in_valid)
                    out_data <= in_data;
            end
            else if (in_valid)
            begin
                x1_q     <= in_data;
                y1_q     <= y;
                out_data <= y;
            end
        end
    end
endmodule // mcp_hpf_section

// ---- design/mcp_capture.sv ----
`timescale 1ns/1ps
// Behaviour
// - phase 0: channel A low, B high
// - phase 1: B low, A high
// - clock low when disabled, else 64fs
// - zero density negative, full density positive
// - chain 1 power bit; chain 2 both
// - bypass sends mixer to output
// - source 0 sends gain data out
// - delay n+1 steps; double step quad
// - per channel delay enable bit
// - offset high-pass cutoff from 2-bit code
// - one offset high-pass disable bit for both converters
// - raised cutoff during init unless disabled
// - voice filter only below high rates
// - gain is code over 128, zero mutes
// - mixer averages, B zero or duplicate
// - two first-order sections, 16-bit coefficients
// - disabled section passes at unity
// - section filters within four samples
// - outputs zero during init cycle
// - mic clock divided from master clock
module mcp_capture #(
    parameter int PDM_HALF = mcp_pkg::PDM_HALF_DIV,
    parameter int CHAIN    = 1
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // microphone link
    output logic                           pdm_clk_out,
    input  wire logic                      pdm_data_in,
    // link and rate setup
    input  wire logic                      pdm_clk_enable,
    input  wire logic                      mic_clk_phase_sel,
    input  wire logic                      quad_rate,
    input  wire logic                      high_rate,
    // phase delay
    input  wire logic [1:0]                phase_delay_enable,
    input  wire logic [1:0][5:0]           phase_delay_code,
    // converter setup
    input  wire logic [1:0]                offset_hpf_cutoff,
    input  wire logic                      offset_hpf_disable,
    input  wire logic                      fast_settle_disable,
    input  wire logic                      filter_type_sel,
    input  wire logic [1:0]                adc_channel_power,
    input  wire logic [15:0]               init_len,
    input  wire logic [1:0][7:0]           sensitivity_code,
    // programmable chain
    input  wire logic                      mono_mix_enable,
    input  wire logic                      mono_duplicate,
    input  wire logic                      chain1_power,
    input  wire logic                      chain2_power,
    input  wire logic                      chain_filter_bypass,
    input  wire logic                      chain_output_source,
    input  wire logic [1:0]                prog_hpf_enable,
    input  wire mcp_pkg::mcp_coef_t [1:0]  prog_hpf_coef,
    // audio out
    output mcp_pkg::mcp_pair_t             serial_audio_out,
    output logic                           audio_valid,
    input  wire logic                      audio_ready,
    // status
    output logic                           init_busy,
    output logic                           overrun
);
    import mcp_pkg::*;

    localparam int DIV_W = $clog2(PDM_HALF + 1);

    logic [DIV_W-1:0]     div_q;
    logic                 pclk_q;
    logic                 div_wrap;
    logic                 low_bit_q;
    logic                 bit_stb;
    logic [5:0]           bit_cnt_q;
    logic                 frame_end;
    logic [1:0]           new_bit;
    logic [1:0]           dly_bit;
    logic [63:0]          dly_q [2];
    logic [7:0]           ones_q [2];
    logic signed [DW-1:0] dec_q [2];
    logic signed [DW-1:0] dprev_q [2];
    logic signed [DW+1:0] hx1_q [2];
    logic signed [DW+1:0] hy1_q [2];
    logic signed [DW+1:0] hp [2];
    logic signed [DW-1:0] s2_q [2];
    logic signed [DW-1:0] mix_q [2];
    logic signed [DW-1:0] sec_out [2];
    logic [1:0]           sec_vld;
    logic                 stb1_q;
    logic                 stb2_q;
    logic                 stb3_q;
    mcp_init_t            init_q;
    logic [15:0]          init_cnt_q;
    logic [1:0]           pwr_prev_q;
    logic [4:0]           hp_shift;
    logic                 voice;
    logic                 chain_on;
    mcp_pair_t            word_q;
    logic                 pend_q;
    logic                 fifo_ready;

    // map ones count of one frame onto the audio scale
    function automatic logic signed [DW-1:0] dec_map(input logic [7:0] ones);
        logic signed [9:0] t;
        t = $signed({1'b0, ones, 1'b0}) - 10'sd64;
        return DW'(t) <<< DEC_SHIFT;
    endfunction

    // mic clock divider
    assign div_wrap = div_q == DIV_W'(PDM_HALF - 1);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q       <= '0;
            pclk_q      <= 1'b0;
            pdm_clk_out <= 1'b0;
        end
        else
        begin
            div_q <= div_wrap ? '0 : div_q + 1'b1;
            if (div_wrap)
                pclk_q <= ~pclk_q;
            pdm_clk_out <= pdm_clk_enable & (div_wrap ? ~pclk_q : pclk_q);
        end
    end

    // capture both phases of the data pin
    assign bit_stb   = div_wrap & pclk_q;
    assign frame_end = bit_stb && (bit_cnt_q == 6'h3f);
    assign new_bit[0] = mic_clk_phase_sel ? pdm_data_in : low_bit_q;
    assign new_bit[1] = mic_clk_phase_sel ? low_bit_q : pdm_data_in;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_bit_q <= 1'b0;
            bit_cnt_q <= '0;
        end
        else
        begin
            if (div_wrap && !pclk_q)
                low_bit_q <= pdm_data_in;
            if (bit_stb)
                bit_cnt_q <= bit_cnt_q + 1'b1;
        end
    end

    // phase delay tap selection
    always_comb
    begin
        for (int g = 0; g < 2; g++)
        begin
            if (!phase_delay_enable[g])
                dly_bit[g] = new_bit[g];
            else if (quad_rate)
                dly_bit[g] = dly_q[g][{phase_delay_code[g][4:0], 1'b1}];
            else
                dly_bit[g] = dly_q[g][phase_delay_code[g]];
        end
    end

    // delay line and integrate-and-dump decimator
    assign voice = filter_type_sel && !high_rate;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stb1_q <= 1'b0;
            for (int g = 0; g < 2; g++)
            begin
                dly_q[g]   <= '0;
                ones_q[g]  <= '0;
                dec_q[g]   <= '0;
                dprev_q[g] <= '0;
            end
        end
        else
        begin
            stb1_q <= frame_end;
            for (int g = 0; g < 2; g++)
            begin
                if (bit_stb)
                begin
                    dly_q[g]  <= {dly_q[g][62:0], new_bit[g]};
                    ones_q[g] <= frame_end ? 8'h00 : ones_q[g] + 8'(dly_bit[g]);
                end
                if (frame_end)
                begin
                    dprev_q[g] <= dec_map(ones_q[g] + 8'(dly_bit[g]));
                    if (voice)
                        dec_q[g] <= DW'((48'(dec_map(ones_q[g] + 8'(dly_bit[g])))
                                         + 48'(dprev_q[g])) >>> 1);
                    else
                        dec_q[g] <= dec_map(ones_q[g] + 8'(dly_bit[g]));
                end
            end
        end
    end

    // initialization cycle, counted in samples
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_q     <= MCP_IDLE;
            init_cnt_q <= '0;
            pwr_prev_q <= '0;
            init_busy  <= 1'b0;
        end
        else
        begin
            pwr_prev_q <= adc_channel_power;
            unique case (init_q)
                MCP_IDLE:
                begin
                    if (pwr_prev_q == 2'b00 && adc_channel_power != 2'b00)
                    begin
                        init_q     <= MCP_INIT;
                        init_cnt_q <= '0;
                    end
                end
                MCP_INIT:
                begin
                    if (adc_channel_power == 2'b00 || init_cnt_q >= init_len)
                        init_q <= MCP_IDLE;
                    else if (stb1_q)
                        init_cnt_q <= init_cnt_q + 1'b1;
                end
            endcase
            init_busy <= init_q == MCP_INIT;
        end
    end

    // offset high-pass
    always_comb
    begin
        unique case (offset_hpf_cutoff)
            2'b00: hp_shift = 5'(HPF_BASE_SHIFT);
            2'b01: hp_shift = 5'(HPF_BASE_SHIFT - 2);
            2'b10: hp_shift = 5'(HPF_BASE_SHIFT - 4);
            2'b11: hp_shift = 5'(HPF_BASE_SHIFT + 2);
        endcase
        if (init_q == MCP_INIT && !fast_settle_disable)
            hp_shift = 5'(HPF_BASE_SHIFT - HPF_FAST_DROP);
        for (int g = 0; g < 2; g++)
        begin
            if (offset_hpf_disable)
                hp[g] = (DW+2)'(dec_q[g]);
            else
                hp[g] = (DW+2)'(dec_q[g]) - hx1_q[g] + hy1_q[g] - (hy1_q[g] >>> hp_shift);
        end
    end

    // high-pass state, sensitivity gain and mixer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stb2_q <= 1'b0;
            stb3_q <= 1'b0;
            for (int g = 0; g < 2; g++)
            begin
                hx1_q[g] <= '0;
                hy1_q[g] <= '0;
                s2_q[g]  <= '0;
                mix_q[g] <= '0;
            end
        end
        else
        begin
            stb2_q <= stb1_q;
            stb3_q <= stb2_q;
            for (int g = 0; g < 2; g++)
            begin
                if (stb1_q)
                begin
                    hx1_q[g] <= (DW+2)'(dec_q[g]);
                    hy1_q[g] <= offset_hpf_disable ? '0 : hp[g];
                    if (init_q == MCP_INIT || !adc_channel_power[g])
                        s2_q[g] <= '0;
                    else
                        s2_q[g] <= mcp_sat((48'(hp[g]) * $signed(48'(sensitivity_code[g])))
                                           >>> GAIN_SHIFT);
                end
            end
            if (stb2_q)
            begin
                if (!mono_mix_enable)
                begin
                    mix_q[0] <= s2_q[0];
                    mix_q[1] <= s2_q[1];
                end
                else
                begin
                    mix_q[0] <= DW'((48'(s2_q[0]) + 48'(s2_q[1])) >>> 1);
                    mix_q[1] <= mono_duplicate
                              ? DW'((48'(s2_q[0]) + 48'(s2_q[1])) >>> 1) : '0;
                end
            end
        end
    end

    // programmable high-pass, two sections per channel
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        logic signed [DW-1:0] mid;
        logic                 mid_vld;

        mcp_hpf_section u_sec0 (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .enable    (prog_hpf_enable[0]),
            .coef      (prog_hpf_coef[0]),
            .in_valid  (stb3_q),
            .in_data   (mix_q[g]),
            .out_valid (mid_vld),
            .out_data  (mid)
        );

        mcp_hpf_section u_sec1 (
            .mclk      (mclk),
            .rst_n     (rst_n),
            .enable    (prog_hpf_enable[1]),
            .coef      (prog_hpf_coef[1]),
            .in_valid  (mid_vld),
            .in_data   (mid),
            .out_valid (sec_vld[g]),
            .out_data  (sec_out[g])
        );
    end

    // chain power and output routing
    assign chain_on = (CHAIN == 1) ? chain1_power : (chain1_power && chain2_power);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_q  <= '0;
            pend_q  <= 1'b0;
            overrun <= 1'b0;
        end
        else
        begin
            if (sec_vld[0])
            begin
                pend_q <= 1'b1;
                if (pend_q && !fifo_ready)
                    overrun <= 1'b1;
                if (!chain_output_source)
                    word_q <= '{a: s2_q[0], b: s2_q[1]};
                else if (!chain_on)
                    word_q <= '0;
                else if (chain_filter_bypass)
                    word_q <= '{a: mix_q[0], b: mix_q[1]};
                else
                    word_q <= '{a: sec_out[0], b: sec_out[1]};
            end
            else if (fifo_ready)
                pend_q <= 1'b0;
        end
    end

    // output buffer
    mcp_fifo #(
        .W     ($bits(mcp_pair_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_valid  (pend_q),
        .in_ready  (fifo_ready),
        .in_data   (word_q),
        .out_valid (audio_valid),
        .out_ready (audio_ready),
        .out_data  (serial_audio_out)
    );
endmodule // mcp_capture

// ---- tb/mcp_capture_assertions.sv ----
`timescale 1ns/1ps
module mcp_capture_assertions #(
    parameter int PDM_HALF = 2
) (
    // clock and reset
    input wire logic               mclk,
    input wire logic               rst_n,
    // microphone link
    input wire logic               pdm_clk_out,
    input wire logic               pdm_clk_enable,
    // converter and output
    input wire logic [1:0]         adc_channel_power,
    input wire logic               init_busy,
    input wire mcp_pkg::mcp_pair_t serial_audio_out,
    input wire logic               audio_valid,
    input wire logic               audio_ready,
    input wire logic               overrun
);
    import mcp_pkg::*;

    logic       prev_q;
    logic       seen_q;
    logic [7:0] run_q;

    // run length, armed at first fall
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= 1'b0;
            seen_q <= 1'b0;
            run_q  <= 8'h00;
        end
        else
        begin
            prev_q <= pdm_clk_out;
            seen_q <= pdm_clk_enable && (seen_q || (prev_q && !pdm_clk_out));
            run_q  <= (pdm_clk_out != prev_q) ? 8'h00 : run_q + 8'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_clk_off;
        !pdm_clk_enable && !$past(pdm_clk_enable) |-> !pdm_clk_out;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("mic clock runs while off");

    property p_clk_stop;
        $fell(pdm_clk_enable) |=> !pdm_clk_out;
    endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("mic clock not stopped");

    property p_clk_half;
        pdm_clk_enable && seen_q && pdm_clk_out != prev_q |-> run_q == PDM_HALF - 1;
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("mic clock half period wrong");

    property p_clk_runs;
        pdm_clk_enable && seen_q |-> run_q < PDM_HALF;
    endproperty
    a_clk_runs: assert property (p_clk_runs) else $error("mic clock stuck");

    property p_init_rise;
        adc_channel_power != 2'h0 && $past(adc_channel_power) == 2'h0 |-> ##2 init_busy;
    endproperty
    a_init_rise: assert property (p_init_rise) else $error("init cycle not entered");

    property p_init_off;
        (adc_channel_power == 2'h0) [*4] |-> !init_busy;
    endproperty
    a_init_off: assert property (p_init_off) else $error("init busy while off");

    property p_hold;
        audio_valid && !audio_ready |=> audio_valid && $stable(serial_audio_out);
    endproperty
    a_hold: assert property (p_hold) else $error("output word dropped");

    property p_ovr_keep;
        overrun |=> overrun;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun flag cleared");

    property p_ovr_cause;
        $rose(overrun) |-> $past(audio_valid, 2) && !$past(audio_ready, 2);
    endproperty
    a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without stall");

endmodule // mcp_capture_assertions

bind mcp_capture mcp_capture_assertions #(.PDM_HALF(PDM_HALF)) u_chk (
    .mclk, .rst_n, .pdm_clk_out, .pdm_clk_enable, .adc_channel_power, .init_busy,
    .serial_audio_out, .audio_valid, .audio_ready, .overrun);

// ---- tb/mcp_pdm_mic.sv ----
`timescale 1ns/1ps
module mcp_pdm_mic (
    // link
    input  wire logic pdm_clk,
    output logic      pdm_data,
    // stream levels of the two mics
    input  wire logic low_bit,
    input  wire logic high_bit
);
    always_comb
        pdm_data = pdm_clk ? high_bit : low_bit;
endmodule // mcp_pdm_mic

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import mcp_pkg::*;
    localparam int HALF = 2;
    localparam logic signed [23:0] FS = 24'sh400000;

    logic                  mclk = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  pdm_clk_out;
    logic                  pdm_data_in;
    logic                  low_bit = 1'b1;
    logic                  high_bit = 1'b0;
    logic                  pdm_clk_enable = 1'b1;
    logic                  mic_clk_phase_sel = 1'b0;
    logic                  quad_rate = 1'b0;
    logic                  high_rate = 1'b0;
    logic [1:0]            phase_delay_enable = 2'h0;
    logic [1:0][5:0]       phase_delay_code = '0;
    logic                  filter_type_sel = 1'b0;
    logic [1:0]            offset_hpf_cutoff = 2'h0;
    logic                  offset_hpf_disable = 1'b1;
    logic                  fast_settle_disable = 1'b0;
    logic [1:0]            adc_channel_power = 2'h0;
    logic [15:0]           init_len = 16'h0001;
    logic [1:0][7:0]       sensitivity_code = {8'h80, 8'h80};
    logic                  mono_mix_enable = 1'b0;
    logic                  mono_duplicate = 1'b0;
    logic                  chain1_power = 1'b0;
    logic                  chain2_power = 1'b0;
    logic                  chain_filter_bypass = 1'b1;
    logic                  chain_output_source = 1'b0;
    logic [1:0]            prog_hpf_enable = 2'h0;
    mcp_coef_t [1:0]       prog_hpf_coef = '0;
    mcp_pair_t             serial_audio_out;
    logic                  audio_valid;
    logic                  audio_ready = 1'b0;
    logic                  init_busy;
    logic                  overrun;
    int                    fail_count = 0;
    int                    checked = 0;

    always #4 mclk = ~mclk;

    mcp_pdm_mic u_mic (.pdm_clk(pdm_clk_out), .pdm_data(pdm_data_in),
        .low_bit(low_bit), .high_bit(high_bit));

    mcp_capture #(.PDM_HALF(HALF), .CHAIN(1)) u_dut (
        .mclk, .rst_n, .pdm_clk_out, .pdm_data_in, .pdm_clk_enable, .mic_clk_phase_sel,
        .quad_rate, .high_rate, .phase_delay_enable, .phase_delay_code, .offset_hpf_cutoff,
        .offset_hpf_disable, .fast_settle_disable, .filter_type_sel, .adc_channel_power,
        .init_len, .sensitivity_code, .mono_mix_enable, .mono_duplicate, .chain1_power,
        .chain2_power, .chain_filter_bypass, .chain_output_source, .prog_hpf_enable,
        .prog_hpf_coef, .serial_audio_out, .audio_valid, .audio_ready, .init_busy, .overrun);

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    begin
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    end
    endtask

    task automatic conclude;
    begin
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask

    function automatic logic [23:0] gx(input logic signed [23:0] v, input logic [7:0] c);
        logic signed [47:0] p;
        p = v * $signed({1'b0, c});
        p = p >>> 7;
        return p[23:0];
    endfunction

    task automatic take(output mcp_pair_t w);
        int n;
    begin
        n = 0;
        while (audio_valid !== 1'b1 && n < 2000)
        begin
            @(negedge mclk);
            n++;
        end
        chk(24'(n < 2000), 24'h1, "no word");
        w = serial_audio_out;
        audio_ready = 1'b1;
        @(negedge mclk);
        audio_ready = 1'b0;
    end
    endtask

    task automatic pair(input logic [23:0] ea, input logic [23:0] eb, input int d = 1300);
        mcp_pair_t w;
    begin
        @(negedge mclk);
        audio_ready = 1'b1;
        repeat (d) @(negedge mclk);
        audio_ready = 1'b0;
        @(negedge mclk);
        take(w);
        chk(w.a, ea, "channel a");
        chk(w.b, eb, "channel b");
    end
    endtask

    task automatic set_gain(input logic [7:0] ca, input logic [7:0] cb);
    begin
        adc_channel_power = 2'h0;
        repeat (4) @(negedge mclk);
        sensitivity_code = {cb, ca};
        @(negedge mclk);
        adc_channel_power = 2'h3;
    end
    endtask

    task automatic t_clock;
        int n;
    begin
        pdm_clk_enable = 1'b0;
        n = 0;
        repeat (4) @(negedge mclk);
        repeat (40)
        begin
            @(negedge mclk);
            n += (pdm_clk_out === 1'b0);
        end
        chk(24'(n), 24'd40, "clock idle");
        pdm_clk_enable = 1'b1;
        repeat (12) @(negedge mclk);
        n = 0;
        repeat (40)
        begin
            @(negedge mclk);
            n += (pdm_clk_out !== u_dut.u_chk.prev_q);
        end
        chk(24'(n), 24'(40 / HALF), "clock rate");
        $display("clock test done");
    end
    endtask

    task automatic t_init;
    begin
        init_len = 16'h0004;
        set_gain(8'h80, 8'h80);
        repeat (20) @(negedge mclk);
        chk(24'(init_busy), 24'h1, "init busy");
        pair(24'h0, 24'h0, 480);
        init_len = 16'h0001;
        pair(FS, -FS);
        $display("init test done");
    end
    endtask

    task automatic t_density;
    begin
        for (int s = 0; s < 2; s++)
        begin
            mic_clk_phase_sel = s[0];
            pair(s ? -FS : FS, s ? FS : -FS);
        end
        filter_type_sel = 1'b1;
        high_rate = 1'b1;
        quad_rate = 1'b1;
        phase_delay_enable = 2'h3;
        phase_delay_code = {6'h20, 6'h3f};
        pair(-FS, FS);
        $display("density test done");
    end
    endtask

    task automatic t_gain;
        logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h40, 8'h80, 8'hff};
    begin
        low_bit = 1'b1;
        high_bit = 1'b1;
        foreach (codes[i])
        begin
            set_gain(codes[i], ~codes[i]);
            pair(gx(FS, codes[i]), gx(FS, ~codes[i]));
        end
        $display("gain test done");
    end
    endtask

    task automatic t_chain;
    begin
        set_gain(8'h80, 8'h40);
        chain1_power = 1'b1;
        chain_output_source = 1'b1;
        pair(FS, FS >>> 1);
        mono_mix_enable = 1'b1;
        pair(24'h300000, 24'h0);
        mono_duplicate = 1'b1;
        pair(24'h300000, 24'h300000);
        chain1_power = 1'b0;
        chain2_power = 1'b1;
        pair(24'h0, 24'h0);
        chain_output_source = 1'b0;
        pair(FS, FS >>> 1);
        offset_hpf_disable = 1'b0;
        pair(24'h0, 24'h0);
        offset_hpf_disable = 1'b1;
        $display("chain test done");
    end
    endtask

    task automatic t_sections;
    begin
        mono_mix_enable = 1'b0;
        chain1_power = 1'b1;
        chain_output_source = 1'b1;
        chain_filter_bypass = 1'b0;
        prog_hpf_coef = {16'h4000, 16'h0000, 16'h4000, 16'h0000};
        pair(FS, FS >>> 1);
        prog_hpf_enable = 2'h3;
        pair(24'h0, 24'h0);
        $display("section test done");
    end
    endtask

    task automatic t_overrun;
    begin
        chk(24'(overrun), 24'h0, "overrun early");
        repeat (1700) @(negedge mclk);
        chk(24'(overrun), 24'h1, "overrun");
        audio_ready = 1'b1;
        repeat (4)
        begin
            chk(24'(audio_valid), 24'h1, "fifo depth");
            @(negedge mclk);
        end
        audio_ready = 1'b0;
        @(negedge mclk);
        $display("overrun test done");
    end
    endtask

    initial
    begin
        repeat (8) @(negedge mclk);
        rst_n = 1'b1;
        t_clock();
        t_init();
        t_density();
        t_gain();
        t_chain();
        t_sections();
        t_overrun();
        conclude();
    end

    initial
    begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

endmodule // tb_top
